// ### dv/fromc_host_model.sv
// Purpose: Far-side model: fault source, resonator and host busy gate.
// Assumes: Driven from the bench by task calls.
// Notes: Outputs change just after a rising edge only.
module fromc_host_model (
  input wire logic core_clk,
  input wire logic commandBusyN,
  output logic faultEvent,
  output logic resonatorStopped,
  output logic mayIssue
);
  timeunit 1ns;
  timeprecision 1ns;
  logic playbackStopped;
  // The host holds every command back while the device reports busy.
  assign mayIssue = commandBusyN;
  initial begin
    faultEvent = 1'b0;
    resonatorStopped = 1'b0;
    playbackStopped = 1'b0;
  end
  // Playback on the backup clock may be abnormal, so the host stops it once the flag reads one.
  task automatic stop_playback();
    playbackStopped = 1'b1;
  endtask : stop_playback
  task automatic pulse_fault();
    @(posedge core_clk);
    faultEvent <= 1'b1;
    @(posedge core_clk);
    faultEvent <= 1'b0;
  endtask : pulse_fault
  task automatic set_stop(input logic v);
    @(posedge core_clk);
    resonatorStopped <= v;
  endtask : set_stop
endmodule : fromc_host_model

// ### dv/fromc_top_tb_top.sv
// Purpose: Self-checking bench for the recovery counter and oscillator monitor.
// Assumes: Shortened counts 20/40/80/160 and a 30-cycle switchover.
// Notes: Overflow timing is checked in a small window, not to the cycle.
module fromc_top_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import fromc_pkg::*;
  typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] r; logic e;} fromc_row_t;
  logic core_clk, rst, psel, penable, pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic pready, pslverr, faultEvent, resonatorStopped, mayIssue, ev;
  logic [1:0] cfgPeriodSel;
  logic cfgStandbyOnOverflow;
  logic useRcClock, standbyReturn, commandBusyN, faultOut, irq;
  int errors = 0, nTests = 0, cnt;
  int lims [4] = '{20, 40, 80, 160};
  fromc_row_t rows [7] = '{'{OFS_ERR, 32'h1f, 32'h0, 1'b0}, '{OFS_SAFETY, 32'h1, 32'h1, 1'b0},
    '{OFS_OUTSEL, 32'h3, 32'h3, 1'b0}, '{OFS_IRQ_MASK, 32'h3, 32'h3, 1'b0},
    '{OFS_CMD, 32'h2, 32'h0, 1'b0}, '{OFS_IRQ_STAT, 32'h3, 32'h0, 1'b0},
    '{8'h18, 32'hff, 32'h0, 1'b1}};
  always #50 core_clk = ~core_clk;
  fromc_top #(.CYC125(20), .CYC500(40), .CYC2000(80), .CYC4000(160), .RCSWITCH(30)) u_fromc_top (
    .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .faultEvent(faultEvent), .resonatorStopped(resonatorStopped),
    .cfgPeriodSel(cfgPeriodSel), .cfgStandbyOnOverflow(cfgStandbyOnOverflow),
    .useRcClock(useRcClock), .standbyReturn(standbyReturn), .commandBusyN(commandBusyN),
    .faultOut(faultOut), .irq(irq));
  fromc_host_model u_fromc_host_model (.core_clk(core_clk), .commandBusyN(commandBusyN),
    .faultEvent(faultEvent), .resonatorStopped(resonatorStopped), .mayIssue(mayIssue));
  // ==========================================================================
  // Tasks
  task automatic report_and_stop();
    $display("errors=%0d nTests=%0d", errors, nTests);
    if (errors == 0 && nTests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    nTests++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic hang(input int n);
    if (n >= 400) begin
      errors++;
      report_and_stop();
    end
  endtask : hang
  // The bench waits for a free device first, so busy spans are honoured.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    i = 0;
    @(negedge core_clk);
    while (mayIssue !== 1'b1 && i < 400) begin
      @(negedge core_clk);
      i++;
    end
    hang(i);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge core_clk);
      i++;
    end while (pready !== 1'b1 && i < 400);
    hang(i);
    rv = prdata;
    ev = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rdm(input string nm, input logic [7:0] a, input logic [31:0] m,
      input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(nm, exp, rv & m);
  endtask : rdm
  task automatic do_reset(input logic [1:0] p, input logic s);
    u_fromc_host_model.set_stop(1'b0);
    rst <= 1'b1;
    cfgPeriodSel <= p;
    cfgStandbyOnOverflow <= s;
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
  endtask : do_reset
  task automatic wait_n(input int n);
    repeat (n) @(negedge core_clk);
  endtask : wait_n
  // ==========================================================================
  // Main sequence
  initial begin
    core_clk = 1'b0;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    cfgPeriodSel = 2'h2;
    cfgStandbyOnOverflow = 1'b0;
    do_reset(2'h2, 1'b0);
    rdm("safety", OFS_SAFETY, 32'hffffffff, 32'h0);
    rdm("outsel", OFS_OUTSEL, 32'hffffffff, 32'h0);
    chk("idle outputs", 32'h2, {irq, useRcClock, commandBusyN, faultOut});
    foreach (rows[k]) begin
      apb(1'b1, rows[k].a, rows[k].w);
      chk("wr err", rows[k].e, ev);
      rdm("row", rows[k].a, 32'hffffffff, rows[k].r);
      chk("rd err", rows[k].e, ev);
    end
    for (int p = 0; p < 4; p++) begin
      do_reset(p[1:0], 1'b1);
      apb(1'b1, OFS_OUTSEL, 32'h1);
      apb(1'b1, OFS_IRQ_MASK, 32'h1);
      apb(1'b1, OFS_SAFETY, 32'h1);
      apb(1'b1, OFS_SAFETY, 32'h0);
      rdm("armed", OFS_ERR, 32'h1f, 32'h10);
      u_fromc_host_model.pulse_fault();
      cnt = 0;
      while (standbyReturn !== 1'b1 && cnt < 400) begin
        @(negedge core_clk);
        cnt++;
      end
      hang(cnt);
      chk("period ok", 1'b1, cnt >= lims[p] - 1 && cnt <= lims[p] + 4);
      chk("flag out", 2'h3, {faultOut, irq});
      rdm("safety cleared", OFS_SAFETY, 32'h3, 32'h0);
      rdm("outsel kept", OFS_OUTSEL, 32'h3, 32'h1);
      apb(1'b1, OFS_IRQ_STAT, 32'h1);
      wait_n(1);
      chk("irq cleared", 1'b0, irq);
      rdm("flag kept", OFS_ERR, 32'h1, 32'h1);
      apb(1'b1, OFS_CMD, 32'h1);
      rdm("flag clear", OFS_ERR, 32'h1, 32'h0);
    end
    do_reset(2'h0, 1'b0);
    apb(1'b1, OFS_SAFETY, 32'h1);
    u_fromc_host_model.pulse_fault();
    wait_n(5);
    apb(1'b1, OFS_CMD, 32'h1);
    wait_n(40);
    rdm("stopped", OFS_ERR, 32'h5, 32'h0);
    u_fromc_host_model.pulse_fault();
    wait_n(3);
    rdm("restart", OFS_ERR, 32'h5, 32'h4);
    wait_n(30);
    rdm("no standby", OFS_SAFETY, 32'h1, 32'h1);
    rdm("overflow", OFS_ERR, 32'h1, 32'h1);
    apb(1'b1, OFS_OUTSEL, 32'h3);
    wait_n(1);
    chk("any out", 1'b1, faultOut);
    do_reset(2'h2, 1'b0);
    apb(1'b1, OFS_SAFETY, 32'h2);
    apb(1'b1, OFS_OUTSEL, 32'h2);
    apb(1'b1, OFS_IRQ_MASK, 32'h2);
    u_fromc_host_model.set_stop(1'b1);
    apb(1'b1, OFS_CMD, 32'h2);
    wait_n(1);
    chk("busy low", 1'b0, commandBusyN);
    rdm("osc flag", OFS_ERR, 32'ha, 32'ha);
    if (rv[BIT_ERR_OSC] === 1'b1) begin
      u_fromc_host_model.stop_playback();
    end
    chk("stop issued", 1'b1, u_fromc_host_model.playbackStopped);
    chk("rc out", 3'h7, {useRcClock, faultOut, irq});
    apb(1'b1, OFS_CMD, 32'h1);
    rdm("reflag", OFS_ERR, 32'h2, 32'h2);
    u_fromc_host_model.set_stop(1'b0);
    wait_n(3);
    rdm("sticky", OFS_ERR, 32'h2, 32'h2);
    apb(1'b1, OFS_CMD, 32'h1);
    rdm("osc clear", OFS_ERR, 32'h2, 32'h0);
    do_reset(2'h2, 1'b0);
    u_fromc_host_model.set_stop(1'b1);
    wait_n(40);
    chk("rc no det", 1'b1, useRcClock);
    rdm("no flag", OFS_ERR, 32'ha, 32'h8);
    report_and_stop();
  end
endmodule : fromc_top_tb_top

// ### src/fromc_pkg.sv
// Purpose: Shared constants for the fault recovery and oscillator-stop monitor.
// Assumes: Core clock of 10 MHz.
// Notes: Register map, field positions, reset values and timing counts.
package fromc_pkg;
  // ==========================================================================
  // Clock and timing
  localparam int unsigned CLK_HZ = 10000000;
  localparam int unsigned PERIOD_125_MS = 125;
  localparam int unsigned PERIOD_500_MS = 500;
  localparam int unsigned PERIOD_2000_MS = 2000;
  localparam int unsigned PERIOD_4000_MS = 4000;
  localparam int unsigned CYC_125 = PERIOD_125_MS * (CLK_HZ / 1000);
  localparam int unsigned CYC_500 = PERIOD_500_MS * (CLK_HZ / 1000);
  localparam int unsigned CYC_2000 = PERIOD_2000_MS * (CLK_HZ / 1000);
  localparam int unsigned CYC_4000 = PERIOD_4000_MS * (CLK_HZ / 1000);
  localparam int unsigned RC_SWITCH_US = 500;
  localparam int unsigned RC_SWITCH_CYC = RC_SWITCH_US * (CLK_HZ / 1000000);
  localparam int unsigned CNT_W = 26;
  // ==========================================================================
  // Register offsets
  localparam logic [7:0] OFS_SAFETY = 8'h00;
  localparam logic [7:0] OFS_CMD = 8'h04;
  localparam logic [7:0] OFS_ERR = 8'h08;
  localparam logic [7:0] OFS_OUTSEL = 8'h0c;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
  // ==========================================================================
  // Field positions
  localparam int unsigned BIT_RCEN = 0;
  localparam int unsigned BIT_OSC_STOP_DETECT_ENABLE = 1;
  localparam int unsigned BIT_CMD_CLEAR = 0;
  localparam int unsigned BIT_CMD_READ = 1;
  localparam int unsigned BIT_ERR_RECOV = 0;
  localparam int unsigned BIT_ERR_OSC = 1;
  localparam int unsigned BIT_ST_RUN = 2;
  localparam int unsigned BIT_ST_RC = 3;
  localparam int unsigned BIT_ST_ARMED = 4;
  // ==========================================================================
  // Reset values and encodings
  localparam logic [1:0] SAFETY_RST = 2'h0;
  localparam logic [1:0] OUTSEL_RST = 2'h0;
  localparam logic [1:0] IRQ_MASK_RST = 2'h0;
  localparam logic [1:0] PSEL_2S = 2'h2;
  typedef enum logic [1:0] {FROMC_OUT_NONE, FROMC_OUT_RECOV, FROMC_OUT_OSC, FROMC_OUT_ANY}
    fromc_outsel_t;
endpackage : fromc_pkg

// ### src/fromc_tick_counter.sv
// Purpose: Up-counter that runs from zero and flags reaching its limit.
// Assumes: Limit is at least one.
// Notes: A start while running restarts from zero.
module fromc_tick_counter #(
  parameter int unsigned W = 26
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic start,
  input wire logic stop,
  input wire logic [W-1:0] limit,
  output logic running,
  output logic done
);
  logic [W-1:0] count_q;
  logic running_q;

  // ==========================================================================
  // Counter
  always_ff @(posedge core_clk) begin
    if (rst) begin
      count_q <= '0;
      running_q <= 1'b0;
    end else if (stop) begin
      count_q <= '0;
      running_q <= 1'b0;
    end else if (start) begin
      count_q <= '0;
      running_q <= 1'b1;
    end else if (running_q) begin
      if (count_q == limit - W'(1)) begin
        running_q <= 1'b0;
        count_q <= '0;
      end else begin
        count_q <= count_q + W'(1);
      end
    end
  end

  assign running = running_q;
  // A stop in the last cycle still reports the limit, so a flag set beats a clear.
  assign done = running_q && !start && (count_q == limit - W'(1));
endmodule : fromc_tick_counter

// ### src/fromc_top.sv
// Purpose: Recovery counter and oscillator-stop monitor behind an APB slave.
// Assumes: Fault and oscillator inputs are synchronous to core_clk.
// Notes: Period and standby action are fixed configuration inputs.
// Contract
// - Recovery detection starts when the enable bit is written to one.
// - Once started, detection keeps running even if the enable bit returns to zero.
// - Recovery counter starts counting only after a fault event.
// - Error clear before overflow stops the counter until the next event.
// - Counter overflow sets the recovery overflow flag.
// - Read-error returns the recovery flag; error clear clears it.
// - Period defaults to 2 s, selectable 125 ms, 500 ms, 2 s, 4 s.
// - Period and standby action come from fixed configuration, not commands.
// - Overflow-forced standby clears every safety enable bit.
// - Standby keeps error flags and output selection; only error clear clears flags.
// - Fault output shows status chosen by the output select register.
// - Enabled oscillator stop sets its flag and switches to the RC clock.
// - Read-error during RC switchover holds busy low; host waits for busy high.
// - Error clear clears the oscillator flag; it resets while stop persists.
// - Disabled detection leaves the flag at zero but still switches to RC.
module fromc_top
  import fromc_pkg::*;
#(
  parameter int unsigned CYC125 = fromc_pkg::CYC_125,
  parameter int unsigned CYC500 = fromc_pkg::CYC_500,
  parameter int unsigned CYC2000 = fromc_pkg::CYC_2000,
  parameter int unsigned CYC4000 = fromc_pkg::CYC_4000,
  parameter int unsigned RCSWITCH = fromc_pkg::RC_SWITCH_CYC
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic faultEvent,
  input wire logic resonatorStopped,
  input wire logic [1:0] cfgPeriodSel,
  input wire logic cfgStandbyOnOverflow,
  output logic useRcClock,
  output logic standbyReturn,
  output logic commandBusyN,
  output logic faultOut,
  output logic irq
);
  import fromc_pkg::*;

  logic [1:0] safety_q;
  logic armed_q;
  logic recovFlag_q;
  logic oscFlag_q;
  fromc_outsel_t outSel_q;
  logic [1:0] irqStat_q;
  logic [1:0] irqMask_q;
  logic [31:0] prdata_q;
  logic rdPend_q;
  logic rcClock_q;
  logic standby_q;
  logic [CNT_W-1:0] period;
  logic cntRun;
  logic overflow;
  logic swRun;
  logic swDone;
  logic setupPh;
  logic wrEn;
  logic mapped;
  logic clearCmd;
  logic readCmd;
  logic oscSet;
  logic stopRise;
  logic stopPrev_q;

  // ==========================================================================
  // APB slave
  assign setupPh = psel && !penable;
  assign wrEn = psel && penable && pwrite;
  assign mapped = (paddr == OFS_SAFETY) || (paddr == OFS_CMD) || (paddr == OFS_ERR) ||
    (paddr == OFS_OUTSEL) || (paddr == OFS_IRQ_STAT) || (paddr == OFS_IRQ_MASK);
  // Zero wait states: read data is captured in the setup cycle.
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata = prdata_q;
  assign clearCmd = wrEn && (paddr == OFS_CMD) && pwdata[BIT_CMD_CLEAR];
  assign readCmd = wrEn && (paddr == OFS_CMD) && pwdata[BIT_CMD_READ];

  always_ff @(posedge core_clk) begin
    if (rst) begin
      prdata_q <= '0;
    end else if (setupPh && !pwrite) begin
      unique case (paddr)
        OFS_SAFETY: prdata_q <= {30'h0, safety_q};
        OFS_ERR: prdata_q <= {27'h0, armed_q, rcClock_q, cntRun, oscFlag_q, recovFlag_q};
        OFS_OUTSEL: prdata_q <= {30'h0, outSel_q};
        OFS_IRQ_STAT: prdata_q <= {30'h0, irqStat_q};
        OFS_IRQ_MASK: prdata_q <= {30'h0, irqMask_q};
        default: prdata_q <= '0;
      endcase
    end
  end

  // ==========================================================================
  // Safety configuration and output select
  always_ff @(posedge core_clk) begin
    if (rst) begin
      safety_q <= SAFETY_RST;
    end else if (standby_q) begin
      safety_q <= SAFETY_RST;
    end else if (wrEn && paddr == OFS_SAFETY) begin
      safety_q <= pwdata[1:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      outSel_q <= fromc_outsel_t'(OUTSEL_RST);
    end else if (wrEn && paddr == OFS_OUTSEL) begin
      outSel_q <= fromc_outsel_t'(pwdata[1:0]);
    end
  end

  // ==========================================================================
  // Recovery counter
  // Once armed, the enable bit is no longer consulted, so software cannot stop it.
  always_ff @(posedge core_clk) begin
    if (rst || standby_q) begin
      armed_q <= 1'b0;
    end else if (safety_q[BIT_RCEN]) begin
      armed_q <= 1'b1;
    end
  end

  // Period is a fixed configuration, never written by a command.
  always_comb begin
    unique case (cfgPeriodSel)
      2'h0: period = CNT_W'(CYC125);
      2'h1: period = CNT_W'(CYC500);
      2'h2: period = CNT_W'(CYC2000);
      default: period = CNT_W'(CYC4000);
    endcase
  end

  fromc_tick_counter #(
    .W(CNT_W)
  ) u_recov (
    .core_clk(core_clk),
    .rst(rst),
    .start(armed_q && faultEvent && !cntRun),
    .stop(clearCmd),
    .limit(period),
    .running(cntRun),
    .done(overflow)
  );

  always_ff @(posedge core_clk) begin
    if (rst) begin
      recovFlag_q <= 1'b0;
    end else if (overflow) begin
      recovFlag_q <= 1'b1;
    end else if (clearCmd) begin
      recovFlag_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      standby_q <= 1'b0;
    end else begin
      standby_q <= overflow && cfgStandbyOnOverflow;
    end
  end
  assign standbyReturn = standby_q;

  // ==========================================================================
  // Oscillator-stop monitor
  always_ff @(posedge core_clk) begin
    if (rst) begin
      stopPrev_q <= 1'b0;
    end else begin
      stopPrev_q <= resonatorStopped;
    end
  end
  assign stopRise = resonatorStopped && !stopPrev_q;

  fromc_tick_counter #(
    .W(CNT_W)
  ) u_switch (
    .core_clk(core_clk),
    .rst(rst),
    .start(stopRise && !rcClock_q),
    .stop(1'b0),
    .limit(CNT_W'(RCSWITCH)),
    .running(swRun),
    .done(swDone)
  );

  // The RC clock stays selected until reset; the resonator is not trusted again.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rcClock_q <= 1'b0;
    end else if (swDone) begin
      rcClock_q <= 1'b1;
    end
  end
  assign useRcClock = rcClock_q;

  assign oscSet = resonatorStopped && safety_q[BIT_OSC_STOP_DETECT_ENABLE];
  always_ff @(posedge core_clk) begin
    if (rst) begin
      oscFlag_q <= 1'b0;
    end else if (oscSet) begin
      oscFlag_q <= 1'b1;
    end else if (clearCmd) begin
      oscFlag_q <= 1'b0;
    end
  end

  // ==========================================================================
  // Command busy
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rdPend_q <= 1'b0;
    end else if (swDone) begin
      rdPend_q <= 1'b0;
    end else if (readCmd && swRun) begin
      rdPend_q <= 1'b1;
    end
  end
  assign commandBusyN = !rdPend_q;

  // ==========================================================================
  // Fault output and interrupts
  always_comb begin
    unique case (outSel_q)
      FROMC_OUT_NONE: faultOut = 1'b0;
      FROMC_OUT_RECOV: faultOut = recovFlag_q;
      FROMC_OUT_OSC: faultOut = oscFlag_q;
      FROMC_OUT_ANY: faultOut = recovFlag_q || oscFlag_q;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      irqStat_q <= '0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if ((i == 0 && overflow) || (i == 1 && oscSet && !oscFlag_q)) begin
          irqStat_q[i] <= 1'b1;
        end else if (wrEn && paddr == OFS_IRQ_STAT && pwdata[i]) begin
          irqStat_q[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      irqMask_q <= IRQ_MASK_RST;
    end else if (wrEn && paddr == OFS_IRQ_MASK) begin
      irqMask_q <= pwdata[1:0];
    end
  end
  assign irq = |(irqStat_q & irqMask_q);

  // ==========================================================================
  // Checks
  sequence s_overflow;
    overflow ##1 1'b1;
  endsequence

  chk_armed_sticky: assert property (@(posedge core_clk) disable iff (rst)
    armed_q && !standby_q |=> armed_q) else $error("Armed state dropped without standby.");
  chk_start_needs_event: assert property (@(posedge core_clk) disable iff (rst)
    $rose(cntRun) |-> $past(faultEvent) && $past(armed_q))
    else $error("Counter started without armed fault event.");
  chk_clear_stops: assert property (@(posedge core_clk) disable iff (rst)
    clearCmd |=> !cntRun) else $error("Counter runs after error clear.");
  chk_overflow_flag: assert property (@(posedge core_clk) disable iff (rst)
    s_overflow |-> recovFlag_q) else $error("Overflow did not set flag.");
  chk_standby_clears: assert property (@(posedge core_clk) disable iff (rst)
    overflow && cfgStandbyOnOverflow |-> ##2 safety_q == SAFETY_RST && !armed_q)
    else $error("Standby did not clear enables.");
  chk_standby_keeps: assert property (@(posedge core_clk) disable iff (rst)
    standby_q && !clearCmd |=> recovFlag_q) else $error("Standby lost the error flag.");
  chk_osc_disabled: assert property (@(posedge core_clk) disable iff (rst)
    !oscFlag_q && !safety_q[BIT_OSC_STOP_DETECT_ENABLE] |=> !oscFlag_q) else $error("Flag set while disabled.");
  chk_osc_resets: assert property (@(posedge core_clk) disable iff (rst)
    oscSet |=> oscFlag_q) else $error("Oscillator flag not set while stopped.");
  chk_rc_switch: assert property (@(posedge core_clk) disable iff (rst)
    stopRise && !rcClock_q && !swRun |-> !useRcClock ##1 swRun)
    else $error("Switchover did not start.");
  chk_busy_low: assert property (@(posedge core_clk) disable iff (rst)
    readCmd && swRun && !swDone |=> !commandBusyN until_with swDone)
    else $error("Busy not held low during switchover.");

  // ==========================================================================
  // Flag, clock and busy checks
  // A clear in a set cycle loses to the set, so each clear check skips its own flag's set cycle (overflow, oscSet).
  sequence s_standby_entry;
    overflow && cfgStandbyOnOverflow ##1 standby_q;
  endsequence
  chk_arm_on_enable: assert property (@(posedge core_clk) disable iff (rst)
    safety_q[BIT_RCEN] && !standby_q |=> armed_q)
    else $error("Enable bit did not arm the counter.");
  chk_idle_no_start: assert property (@(posedge core_clk) disable iff (rst)
    !cntRun && !(armed_q && faultEvent) |=> !cntRun)
    else $error("Counter started without a fault event.");
  chk_recov_sticky: assert property (@(posedge core_clk) disable iff (rst)
    recovFlag_q && !clearCmd |=> recovFlag_q)
    else $error("Recovery flag dropped without clear.");
  chk_recov_clear: assert property (@(posedge core_clk) disable iff (rst)
    clearCmd && !overflow |=> !recovFlag_q)
    else $error("Error clear left the recovery flag set.");
  chk_osc_sticky: assert property (@(posedge core_clk) disable iff (rst)
    oscFlag_q && !clearCmd |=> oscFlag_q)
    else $error("Oscillator flag dropped without clear.");
  chk_osc_clear: assert property (@(posedge core_clk) disable iff (rst)
    clearCmd && !oscSet |=> !oscFlag_q)
    else $error("Error clear left the oscillator flag set.");
  chk_rc_after_done: assert property (@(posedge core_clk) disable iff (rst)
    swDone |=> useRcClock)
    else $error("RC clock not selected after switchover.");
  chk_rc_kept: assert property (@(posedge core_clk) disable iff (rst)
    useRcClock |=> useRcClock)
    else $error("RC clock selection dropped.");
  chk_busy_release: assert property (@(posedge core_clk) disable iff (rst)
    swDone |=> commandBusyN)
    else $error("Busy not released after switchover.");
  chk_out_none: assert property (@(posedge core_clk) disable iff (rst)
    outSel_q == FROMC_OUT_NONE |-> !faultOut)
    else $error("Fault output high with no source selected.");
  chk_outsel_kept: assert property (@(posedge core_clk) disable iff (rst)
    standby_q && !(wrEn && paddr == OFS_OUTSEL) |=> $stable(outSel_q))
    else $error("Standby changed the output selection.");
  chk_standby_pulse: assert property (@(posedge core_clk) disable iff (rst)
    s_standby_entry |=> !standby_q)
    else $error("Standby return longer than one cycle.");
endmodule : fromc_top
